// ### design/lbp_pkg.sv
// Package for the loopback and tester path selector of one framer channel.
// Assumes a word-addressed Avalon-MM slave port and one system clock.
package lbp_pkg;

  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int          LBP_AW        = 3;
  localparam int          LBP_DW        = 32;
  localparam logic [2:0]  LBP_IDX_MC2   = 3'h2;
  localparam logic [2:0]  LBP_IDX_TCTL  = 3'h4;
  localparam logic [2:0]  LBP_IDX_FRM   = 3'h5;
  localparam logic [2:0]  LBP_IDX_STAT  = 3'h6;
  localparam int          LBP_MC2_PAY   = 0;
  localparam int          LBP_MC2_LINE  = 1;
  localparam int          LBP_MC2_DIAG  = 2;
  localparam int          LBP_TCTL_EN   = 0;
  localparam int          LBP_TCTL_MODE = 1;
  localparam int          LBP_FRM_CBIT  = 0;
  localparam int          LBP_STAT_CLK  = 3;
  localparam int          LBP_STAT_MODE = 4;
  localparam logic [31:0] LBP_ZERO_WORD = 32'h0000_0000;

  // ****************************************************************
  // Tester route modes
  // ****************************************************************
  localparam logic [1:0] LBP_MODE_RX_PAYLOAD  = 2'h0;
  localparam logic [1:0] LBP_MODE_LINE_GEN    = 2'h1;
  localparam logic [1:0] LBP_MODE_SYS_PAYLOAD = 2'h2;
  localparam logic [1:0] LBP_MODE_SYS_FULL    = 2'h3;
  localparam int         LBP_MODE_SYS_SIDE    = 1;

  typedef enum logic {LBP_BUS_IDLE, LBP_BUS_ACK} lbp_bus_e;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       payload_loop_en;
    logic       line_loop_en;
    logic       diag_loop_en;
    logic       tester_enable;
    logic [1:0] tester_route_mode;
    logic       cbit_copy_en;
  } lbp_cfg_s;

  localparam lbp_cfg_s LBP_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0};

  // Bit position marker of a frame: strobe, start, overhead, C bit, data.
  typedef struct packed {
    logic strobe;
    logic frame_start;
    logic overhead;
    logic cbit;
    logic data;
  } lbp_pos_s;

  // Dual-rail line pair with its bit strobe.
  typedef struct packed {
    logic pos;
    logic neg;
    logic strobe;
  } lbp_rail_s;

  typedef struct packed {
    lbp_bus_e    bus_st;
    logic        waitreq;
    logic [31:0] rdata;
    lbp_cfg_s    cfg;
    lbp_cfg_s    route;
    lbp_rail_s   tx_line;
    lbp_rail_s   dec_rail;
    logic        rx_data;
    logic        tester_bit;
    logic        tester_valid;
    logic        src_bit;
    logic        src_valid;
    logic        src_override;
    logic        frame_start;
    logic        payload_en;
    logic        clk_from_rx;
  } lbp_state_s;

endpackage

// ### design/lbp_path_select.sv
// Loopback and tester path selector for one framer channel.
// Assumes all line and framer strobes are synchronous one-cycle enables of clk_sys.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Payload loopback feeds received payload into the formatter instead of system data, except in mode 01.
// - Payload loopback in modes 0X keeps received data on output; formatter payload ignores system transmit input.
// - Payload loopback realigns transmit frame start and payload enable to receive frame.
// - Overhead insertion replaces the looped bit at any position when enabled.
// - Payload loopback times frame, enable and insertion on the receive output strobe.
// - Diagnostic loopback wins when payload and diagnostic loopback are both set.
// - Payload loopback is active while its configuration bit is set and the diagnostic bit clear, one cycle after the register.
// - Two-bit route mode; upper bit puts the tester on the system transmit side.
// - The tester works only while its enable bit is set.
// - Normal, mode 0X: received payload to tester and output, tester to line.
// - Diagnostic, mode 0X: tester payload to line, tester input and receive output.
// - Line loopback, mode 0X: received payload to line, output and tester.
// - Mode 1X: system data to tester, tester to output; line per loopback.
// - Payload loopback: mode 00 loops received payload, mode 01 sends tester payload.
// - Mode 01 without line loop: tester bits also fill overhead; tester sees overhead.
// - Mode 11: system overhead to tester, tester overhead to output.
// - Overhead: line loop echoes received bits, diagnostic feeds formatter, 00/10 generate none.
// - With C-bit copy, formatter takes C bits from the system transmit stream, except in mode 01 without line loop.
// - Mode 11 expects a full-bandwidth pattern on system input; tester checks it all.
// - Mode 11 with C-bit copy still copies C bits from the test pattern.
// - Diagnostic loopback returns transmit rails and strobe to the receive decoder.
// - Line loopback drives transmit rails and strobe straight from receive rails.
// - Payload loopback switches the internal transmit timing to the receive strobe.
module lbp_path_select
(
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic [lbp_pkg::LBP_AW-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [lbp_pkg::LBP_DW-1:0] avs_writedata,
  output logic      [lbp_pkg::LBP_DW-1:0] avs_readdata,
  output logic                           avs_waitrequest,
  input  wire lbp_pkg::lbp_rail_s        rx_line,
  input  wire logic                      tx_in_strobe,
  input  wire logic                      enc_pos,
  input  wire logic                      enc_neg,
  output lbp_pkg::lbp_rail_s             tx_line,
  output lbp_pkg::lbp_rail_s             dec_rail,
  input  wire lbp_pkg::lbp_pos_s         rx_frame,
  input  wire lbp_pkg::lbp_pos_s         fmt_frame,
  input  wire logic                      tx_system_data_in,
  input  wire logic                      tx_overhead_data_in,
  input  wire logic                      tx_overhead_insert_en,
  input  wire logic                      tester_tx_bit,
  output logic                           rx_system_data_out,
  output logic                           tester_rx_bit,
  output logic                           tester_rx_valid,
  output logic                           fmt_src_bit,
  output logic                           fmt_src_valid,
  output logic                           fmt_src_override,
  output logic                           tx_frame_start,
  output logic                           tx_payload_enable,
  output logic                           tx_clk_from_rx
);
  import lbp_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Word index match, shared by read and write decoding.
  function automatic logic lbp_hit(input logic [LBP_AW-1:0] addr, input logic [LBP_AW-1:0] idx);
    lbp_hit = (addr == idx);
  endfunction

  lbp_state_s st_reg;
  lbp_state_s st_next;
  logic       pay_w;
  logic       sys_w;
  logic       gen_w;
  logic       full_w;
  logic       oh_w;
  logic       tb_w;
  logic       ins_w;
  logic       txs_w;
  lbp_pos_s   pos_w;
  lbp_rail_s  txl_w;
  logic       pay_src_w;
  logic       oh_src_w;
  logic       oh_ovr_w;
  logic       t_oh_w;
  logic       take_w;

  // ****************************************************************
  // Route decoding
  // ****************************************************************

  // Decoding works on the registered route copy so a register write never glitches a mux.
  always_comb
  begin
    pay_w  = st_reg.route.payload_loop_en & ~st_reg.route.diag_loop_en;
    sys_w  = st_reg.route.tester_route_mode[LBP_MODE_SYS_SIDE];
    gen_w  = (st_reg.route.tester_route_mode == LBP_MODE_LINE_GEN);
    full_w = (st_reg.route.tester_route_mode == LBP_MODE_SYS_FULL);
    tb_w   = st_reg.route.tester_enable & tester_tx_bit;
    ins_w  = tx_overhead_insert_en;
    txs_w  = pay_w ? rx_line.strobe : tx_in_strobe;
    pos_w  = pay_w ? rx_frame : fmt_frame;
    oh_w   = pos_w.overhead;
  end

  // ****************************************************************
  // Transmit source selection
  // ****************************************************************

  // Payload source for the formatter; diagnostic loop behaves as normal here because the
  // rails themselves are looped, so the decoded stream already carries the sent bits.
  always_comb
  begin
    if (pay_w)
    begin
      pay_src_w = gen_w ? tb_w : rx_frame.data;
    end
    else
    begin
      pay_src_w = sys_w ? tx_system_data_in : tb_w;
    end
  end

  // Overhead override: insertion first, then tester overhead, then C-bit copy.
  always_comb
  begin
    oh_src_w = 1'b0;
    oh_ovr_w = 1'b0;
    if (gen_w && !st_reg.route.line_loop_en)
    begin
      oh_src_w = tb_w;
      oh_ovr_w = 1'b1;
    end
    else if (st_reg.route.cbit_copy_en && pos_w.cbit)
    begin
      oh_src_w = tx_system_data_in;
      oh_ovr_w = 1'b1;
    end
  end

  // Line rails: line loop echoes the receive pair, otherwise the encoder output goes out.
  always_comb
  begin
    if (st_reg.route.line_loop_en)
    begin
      txl_w = rx_line;
    end
    else
    begin
      txl_w = '{enc_pos, enc_neg, txs_w};
    end
  end

  // Tester sees overhead only in modes 01 and 11; the others carry payload alone.
  always_comb
  begin
    t_oh_w = sys_w ? fmt_frame.overhead : rx_frame.overhead;
    take_w = sys_w ? fmt_frame.strobe : rx_frame.strobe;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************

  // The bus answers one cycle after a request; the write lands on the acknowledge edge.
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg.bus_st)
      LBP_BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          st_next.bus_st  = LBP_BUS_ACK;
          st_next.waitreq = 1'b0;
          st_next.rdata   = LBP_ZERO_WORD;
          if (lbp_hit(avs_address, LBP_IDX_MC2))
          begin
            st_next.rdata[LBP_MC2_PAY]  = st_reg.cfg.payload_loop_en;
            st_next.rdata[LBP_MC2_LINE] = st_reg.cfg.line_loop_en;
            st_next.rdata[LBP_MC2_DIAG] = st_reg.cfg.diag_loop_en;
          end
          else if (lbp_hit(avs_address, LBP_IDX_TCTL))
          begin
            st_next.rdata[LBP_TCTL_EN]                    = st_reg.cfg.tester_enable;
            st_next.rdata[LBP_TCTL_MODE+1:LBP_TCTL_MODE] = st_reg.cfg.tester_route_mode;
          end
          else if (lbp_hit(avs_address, LBP_IDX_FRM))
          begin
            st_next.rdata[LBP_FRM_CBIT] = st_reg.cfg.cbit_copy_en;
          end
          else if (lbp_hit(avs_address, LBP_IDX_STAT))
          begin
            st_next.rdata[LBP_MC2_PAY]                    = pay_w;
            st_next.rdata[LBP_MC2_LINE]                   = st_reg.route.line_loop_en;
            st_next.rdata[LBP_MC2_DIAG]                   = st_reg.route.diag_loop_en;
            st_next.rdata[LBP_STAT_CLK]                   = st_reg.clk_from_rx;
            st_next.rdata[LBP_STAT_MODE+1:LBP_STAT_MODE] = st_reg.route.tester_route_mode;
          end
        end
      end
      LBP_BUS_ACK:
      begin
        st_next.bus_st  = LBP_BUS_IDLE;
        st_next.waitreq = 1'b1;
        if (avs_write && lbp_hit(avs_address, LBP_IDX_MC2))
        begin
          st_next.cfg.payload_loop_en = avs_writedata[LBP_MC2_PAY];
          st_next.cfg.line_loop_en    = avs_writedata[LBP_MC2_LINE];
          st_next.cfg.diag_loop_en    = avs_writedata[LBP_MC2_DIAG];
        end
        if (avs_write && lbp_hit(avs_address, LBP_IDX_TCTL))
        begin
          st_next.cfg.tester_enable     = avs_writedata[LBP_TCTL_EN];
          st_next.cfg.tester_route_mode = avs_writedata[LBP_TCTL_MODE+1:LBP_TCTL_MODE];
        end
        if (avs_write && lbp_hit(avs_address, LBP_IDX_FRM))
        begin
          st_next.cfg.cbit_copy_en = avs_writedata[LBP_FRM_CBIT];
        end
      end
    endcase

    // Registered copy of the settings that every mux below follows.
    st_next.route = st_reg.cfg;

    // Rails toward the line and toward the receive decoder.
    st_next.tx_line = txl_w;
    if (st_reg.route.diag_loop_en)
    begin
      st_next.dec_rail = '{txl_w.pos, txl_w.neg, txs_w};
    end
    else
    begin
      st_next.dec_rail = rx_line;
    end

    // Receive output: tester bits on the system side, else the received stream.
    if (sys_w && (!rx_frame.overhead || full_w))
    begin
      st_next.rx_data = tb_w;
    end
    else
    begin
      st_next.rx_data = rx_frame.data;
    end

    // Tester input: system stream in modes 1X, whole frame in mode 11.
    st_next.tester_bit   = sys_w ? tx_system_data_in : rx_frame.data;
    st_next.tester_valid = st_reg.route.tester_enable & take_w &
                           (~t_oh_w | gen_w | full_w);

    // Formatter source; insertion overwrites any bit position.
    st_next.src_valid = pos_w.strobe;
    if (ins_w)
    begin
      st_next.src_bit      = tx_overhead_data_in;
      st_next.src_override = 1'b1;
    end
    else
    begin
      st_next.src_bit      = oh_w ? oh_src_w : pay_src_w;
      st_next.src_override = oh_w & oh_ovr_w;
    end

    // Frame timing follows the receiver during payload loopback.
    st_next.frame_start = pos_w.strobe & pos_w.frame_start;
    st_next.payload_en  = pos_w.strobe & ~oh_w;
    st_next.clk_from_rx = pay_w;
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset acts even with the clock enable low so a frozen block can still be cleared.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st_reg              <= '0;
      st_reg.bus_st       <= LBP_BUS_IDLE;
      st_reg.waitreq      <= 1'b1;
      st_reg.cfg          <= LBP_CFG_RST;
      st_reg.route        <= LBP_CFG_RST;
    end
    else if (clk_en)
    begin
      st_reg <= st_next;
    end
  end

  // Every output comes straight from the state register.
  assign avs_readdata       = st_reg.rdata;
  assign avs_waitrequest    = st_reg.waitreq;
  assign tx_line            = st_reg.tx_line;
  assign dec_rail           = st_reg.dec_rail;
  assign rx_system_data_out = st_reg.rx_data;
  assign tester_rx_bit      = st_reg.tester_bit;
  assign tester_rx_valid    = st_reg.tester_valid;
  assign fmt_src_bit        = st_reg.src_bit;
  assign fmt_src_valid      = st_reg.src_valid;
  assign fmt_src_override   = st_reg.src_override;
  assign tx_frame_start     = st_reg.frame_start;
  assign tx_payload_enable  = st_reg.payload_en;
  assign tx_clk_from_rx     = st_reg.clk_from_rx;

  // ****************************************************************
  // Checks
  // ****************************************************************

  pay_src_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(pay_w) && !$past(gen_w) && !$past(ins_w) && !$past(oh_w)
      |-> fmt_src_bit == $past(rx_frame.data))
    else $error("Looped payload not fed to formatter.");

  rx_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(pay_w) && !$past(sys_w) |-> rx_system_data_out == $past(rx_frame.data))
    else $error("Receive output lost during payload loop.");

  realign_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(pay_w)
      |-> tx_frame_start == ($past(rx_frame.strobe) && $past(rx_frame.frame_start)))
    else $error("Frame start not aligned to receiver.");

  oh_insert_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(ins_w) |-> fmt_src_override && fmt_src_bit == $past(tx_overhead_data_in))
    else $error("Overhead insertion ignored.");

  diag_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(st_reg.route.diag_loop_en) |-> !tx_clk_from_rx)
    else $error("Payload loop active under diagnostic loop.");

  route_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(st_reg.cfg.payload_loop_en) && !$past(st_reg.cfg.diag_loop_en)
      ##1 $past(clk_en) |-> tx_clk_from_rx)
    else $error("Payload loop did not follow its setting.");

  tester_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && !$past(st_reg.route.tester_enable) |-> !tester_rx_valid)
    else $error("Tester active while disabled.");

  line_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(st_reg.route.line_loop_en) |-> tx_line == $past(rx_line))
    else $error("Line loop does not echo receive rails.");

  diag_rail_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(clk_en) && $past(st_reg.route.diag_loop_en)
      |-> dec_rail.pos == tx_line.pos && dec_rail.neg == tx_line.neg)
    else $error("Diagnostic loop does not return transmit rails.");

  bus_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest || !$past(clk_en))
    else $error("Bus request not acknowledged.");

endmodule

// ### tb/lbp_liu_model.sv
// Line interface stand-in: receive rails with a sparse bit strobe, count of transmit strobes.
// Assumes the bench sets the rail levels and that everything runs on clk_sys.
`timescale 1ns/1ps
module lbp_liu_model
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               rail_pos,
  input  wire logic               rail_neg,
  input  wire lbp_pkg::lbp_rail_s tx_line,
  output lbp_pkg::lbp_rail_s      rx_line,
  output logic [7:0]              tx_count
);
  import lbp_pkg::*;
  logic [1:0] div_reg;

  // ******************************
  // Receive strobe and transmit count
  // ******************************
  // One bit every third cycle, so a path that uses the wrong strobe shows a different count.
  // Rails stay driven between strobes, as a line driver never releases them.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      div_reg  <= 2'h0;
      tx_count <= 8'h00;
    end
    else
    begin
      div_reg  <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      tx_count <= tx_count + {7'h00, tx_line.strobe};
    end
  end

  // Rails follow the bench levels; the strobe marks the bit.
  assign rx_line = '{rail_pos, rail_neg, div_reg == 2'h2};
endmodule

// ### tb/tb.sv
// Self-checking bench for the loopback and tester path selector.
// Assumes lbp_pkg, lbp_path_select and lbp_liu_model are compiled first.
`timescale 1ns/1ps
module tb;
  import lbp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, clk_en, avs_read, avs_write, avs_waitrequest, rail_pos, rail_neg, tx_in_strobe, enc_pos, enc_neg;
  logic [LBP_AW-1:0] avs_address;
  logic [LBP_DW-1:0] avs_writedata, avs_readdata, q;
  lbp_rail_s rx_line, tx_line, dec_rail;
  lbp_pos_s  rx_frame, fmt_frame;
  logic tx_system_data_in, tx_overhead_data_in, tx_overhead_insert_en, tester_tx_bit, rx_system_data_out;
  logic tester_rx_bit, tester_rx_valid, fmt_src_bit, fmt_src_valid, fmt_src_override;
  logic tx_frame_start, tx_payload_enable, tx_clk_from_rx;
  logic [7:0] tx_count, c0;
  int   v;
  int   mismatches = 0;
  int   compares = 0;

  lbp_path_select u_lbp_path_select (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_line(rx_line),
    .tx_in_strobe(tx_in_strobe), .enc_pos(enc_pos), .enc_neg(enc_neg), .tx_line(tx_line), .dec_rail(dec_rail),
    .rx_frame(rx_frame), .fmt_frame(fmt_frame), .tx_system_data_in(tx_system_data_in),
    .tx_overhead_data_in(tx_overhead_data_in), .tx_overhead_insert_en(tx_overhead_insert_en),
    .tester_tx_bit(tester_tx_bit), .rx_system_data_out(rx_system_data_out), .tester_rx_bit(tester_rx_bit),
    .tester_rx_valid(tester_rx_valid), .fmt_src_bit(fmt_src_bit), .fmt_src_valid(fmt_src_valid),
    .fmt_src_override(fmt_src_override), .tx_frame_start(tx_frame_start),
    .tx_payload_enable(tx_payload_enable), .tx_clk_from_rx(tx_clk_from_rx));

  lbp_liu_model u_lbp_liu_model (.clk_sys(clk_sys), .rst_n(rst_n), .rail_pos(rail_pos), .rail_neg(rail_neg),
    .tx_line(tx_line), .rx_line(rx_line), .tx_count(tx_count));

  // Half period of the 50 ns system clock.
  always #25 clk_sys = ~clk_sys;

  // ******************************
  // Checking and bus tasks
  // ******************************
  task automatic test_done;
  begin
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task automatic chk1(input logic got, input logic exp);
  begin
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t bit got %b expected %b", $time, got, exp);
    end
  end
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
  begin
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // The request is held until waitrequest is sampled low at a rising edge; data is taken there.
  task automatic bus(input logic wr, input logic [2:0] adr, input logic [31:0] wd);
    int n;
  begin
    @(posedge clk_sys);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      test_done();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  end
  endtask

  task automatic rd(input logic [2:0] adr, input logic [31:0] exp);
  begin
    bus(1'b0, adr, LBP_ZERO_WORD);
    chkw(q, exp);
  end
  endtask

  // Holds a set of path inputs long enough for the route copy and the output stage to follow.
  task automatic setp(input lbp_pos_s rf, input lbp_pos_s ff, input logic sd, input logic od, input logic oe,
                      input logic tbit);
  begin
    @(posedge clk_sys);
    rx_frame <= rf;
    fmt_frame <= ff;
    tx_system_data_in <= sd;
    tx_overhead_data_in <= od;
    tx_overhead_insert_en <= oe;
    tester_tx_bit <= tbit;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  end
  endtask

  // ******************************
  // Main sequence
  // ******************************
  initial
  begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata, rail_pos, rail_neg} = '0;
    {tx_in_strobe, enc_pos, enc_neg, rx_frame, fmt_frame, tx_system_data_in} = '0;
    {tx_overhead_data_in, tx_overhead_insert_en, tester_tx_bit} = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk1(avs_waitrequest, 1'b1);
    chkw(avs_readdata, LBP_ZERO_WORD);
    rd(LBP_IDX_MC2, 32'h0000_0000);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0007);
    rd(LBP_IDX_MC2, 32'h0000_0007);
    bus(1'b1, 3'h7, 32'hFFFF_FFFF);
    rd(3'h7, 32'h0000_0000);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0000);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0001);
    setp(5'h11, 5'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    chk1(rx_system_data_out, 1'b1);
    chk1(tester_rx_bit, 1'b1);
    chk1(tester_rx_valid, 1'b1);
    chk1(fmt_src_bit, 1'b0);
    chk1(tx_clk_from_rx, 1'b0);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0005);
    for (v = 0; v < 2; v++)
    begin
      setp({4'h8, !v[0]}, 5'h10, v[0], 1'b0, 1'b0, v[0]);
      chk1(tester_rx_bit, v[0]);
      chk1(rx_system_data_out, v[0]);
      chk1(fmt_src_bit, v[0]);
    end
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0004);
    setp(5'h11, 5'h10, 1'b1, 1'b0, 1'b0, 1'b1);
    chk1(rx_system_data_out, 1'b0);
    chk1(tester_rx_valid, 1'b0);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0001);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0001);
    for (v = 0; v < 2; v++)
    begin
      setp({4'h8, v[0]}, 5'h10, !v[0], 1'b0, 1'b0, !v[0]);
      chk1(fmt_src_bit, v[0]);
      chk1(rx_system_data_out, v[0]);
      chk1(tester_rx_bit, v[0]);
      chk1(tx_clk_from_rx, 1'b1);
      setp({4'h8, v[0]}, 5'h10, !v[0], !v[0], 1'b1, !v[0]);
      chk1(fmt_src_override, 1'b1);
      chk1(fmt_src_bit, !v[0]);
    end
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0003);
    setp(5'h11, 5'h10, 1'b1, 1'b0, 1'b0, 1'b0);
    chk1(fmt_src_bit, 1'b0);
    chk1(rx_system_data_out, 1'b1);
    // Receive frame start must steer the transmit frame start; a formatter start must not.
    @(posedge clk_sys);
    rx_frame <= 5'h18;
    fmt_frame <= 5'h00;
    @(posedge clk_sys);
    rx_frame <= 5'h00;
    fmt_frame <= 5'h18;
    @(negedge clk_sys);
    chk1(tx_frame_start, 1'b1);
    chk1(tx_payload_enable, 1'b1);
    chk1(fmt_src_valid, 1'b1);
    @(negedge clk_sys);
    chk1(tx_frame_start, 1'b0);
    chk1(tx_payload_enable, 1'b0);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0001);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0005);
    setp(5'h11, 5'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    chk1(tx_clk_from_rx, 1'b0);
    rd(LBP_IDX_STAT, 32'h0000_0004);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0004);
    {enc_pos, enc_neg, tx_in_strobe, rail_pos, rail_neg} <= 5'h15;
    setp(5'h10, 5'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    chkw({29'h0, dec_rail}, 32'h0000_0005);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0002);
    {enc_pos, enc_neg, tx_in_strobe, rail_pos, rail_neg} <= 5'h0E;
    setp(5'h10, 5'h10, 1'b0, 1'b0, 1'b0, 1'b0);
    chkw({29'h0, tx_line.pos, tx_line.neg, 1'b0}, 32'h0000_0004);
    c0 = tx_count;
    repeat (12) @(negedge clk_sys);
    chkw({24'h0, tx_count - c0}, 32'h0000_0004);
    bus(1'b1, LBP_IDX_MC2, 32'h0000_0000);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0003);
    setp(5'h15, 5'h14, 1'b0, 1'b0, 1'b0, 1'b0);
    chk1(fmt_src_override, 1'b1);
    chk1(fmt_src_bit, 1'b0);
    chk1(tester_rx_bit, 1'b1);
    bus(1'b1, LBP_IDX_TCTL, 32'h0000_0007);
    setp(5'h15, 5'h14, 1'b0, 1'b0, 1'b0, 1'b0);
    chk1(tester_rx_bit, 1'b0);
    chk1(rx_system_data_out, 1'b0);
    chk1(tester_rx_valid, 1'b1);
    bus(1'b1, LBP_IDX_FRM, 32'h0000_0001);
    for (v = 0; v < 2; v++)
    begin
      bus(1'b1, LBP_IDX_TCTL, v[0] ? 32'h0000_0007 : 32'h0000_0001);
      setp(5'h10, 5'h16, 1'b1, 1'b0, 1'b0, 1'b0);
      chk1(fmt_src_override, 1'b1);
      chk1(fmt_src_bit, 1'b1);
    end
    test_done();
  end
endmodule
